/* File: common/fes_pkg.sv */
// Shared constants for the framer event status flag block
package fes_pkg;

	// ==========================================
	// Device organisation
	localparam int FES_NUM_FRAMERS = 4;
	localparam int FES_REG_W = 8;

	// ==========================================
	// Register map of the parallel control port
	localparam logic [7:0] FES_RX_EVENT_OFFSET = 8'h22;
	localparam logic [7:0] FES_REG_RESET = 8'h00;

	// ==========================================
	// Bit positions of receive_event_flags
	localparam int FES_BIT_ALIGN_CHANGE = 7;
	localparam int FES_BIT_EIGHT_ZERO = 6;
	localparam int FES_BIT_SIXTEEN_ZERO = 5;
	localparam int FES_BIT_STORE_FULL = 4;
	localparam int FES_BIT_STORE_EMPTY = 3;
	localparam int FES_BIT_SEVERE_FRAMING = 2;
	localparam int FES_BIT_B8ZS_SEEN = 1;
	localparam int FES_BIT_FRAMING_ERROR = 0;

	// ==========================================
	// Bit positions inside one framer's pair of summary bits
	localparam int FES_SUM_FIRST = 0;
	localparam int FES_SUM_SECOND = 1;

	// ==========================================
	// Detection thresholds
	localparam int FES_ZERO_SHORT = 8;
	localparam int FES_ZERO_LONG = 16;
	localparam int FES_SEVERE_WINDOW = 6;
	localparam int FES_SEVERE_LIMIT = 2;
	localparam int FES_ALIGN_W = 8;

endpackage

/* File: src/fes_zero_run.sv */
// Consecutive zero run detector for one receive line
`timescale 1ns/1ns
module fes_zero_run
	import fes_pkg::*;
#(
	parameter int SHORT_RUN = FES_ZERO_SHORT,
	parameter int LONG_RUN = FES_ZERO_LONG
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic bit_stb,
	input wire logic line_pos,
	input wire logic line_neg,
	output logic short_evt,
	output logic long_evt
);

	localparam int CNT_W = $clog2(LONG_RUN + 1);
	localparam logic [CNT_W-1:0] SHORT_CNT = CNT_W'(SHORT_RUN);
	localparam logic [CNT_W-1:0] LONG_CNT = CNT_W'(LONG_RUN);
	localparam logic [CNT_W-1:0] ONE_CNT = CNT_W'(1);

	logic [CNT_W-1:0] run_r;
	logic [CNT_W-1:0] run_nxt;
	logic is_zero;

	// ==========================================
	// Run length, saturating so long runs keep reporting
	always_comb
	begin
		is_zero = ~line_pos & ~line_neg;
		run_nxt = run_r;
		if (bit_stb)
		begin
			if (!is_zero)
				run_nxt = '0;
			else if (run_r != LONG_CNT)
				run_nxt = run_r + ONE_CNT;
		end
		// Fires on every zero while the run is long enough, so a flag cleared mid-run sets again
		short_evt = bit_stb & is_zero & (run_nxt >= SHORT_CNT);
		long_evt = bit_stb & is_zero & (run_nxt >= LONG_CNT);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			run_r <= '0;
		else
			run_r <= run_nxt;
	end

endmodule

/* File: src/fes_status_top.sv */
// Receive event flags and interrupt summary for four framers
`timescale 1ns/1ns
module fes_status_top
	import fes_pkg::*;
#(
	parameter int NUM_FRAMERS = FES_NUM_FRAMERS,
	parameter int ALIGN_W = FES_ALIGN_W
)
(
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic [1:0] FRAMER_SEL,
	input wire logic [7:0] ADDR,
	input wire logic WR_STB,
	input wire logic RD_STB,
	input wire logic [7:0] WR_DATA,
	output logic [7:0] RD_DATA,
	output logic RD_VALID,
	input wire logic [NUM_FRAMERS-1:0] RX_BIT_STB,
	input wire logic [NUM_FRAMERS-1:0] RX_LINE_POSITIVE,
	input wire logic [NUM_FRAMERS-1:0] RX_LINE_NEGATIVE,
	input wire logic [NUM_FRAMERS-1:0] RX_B8ZS_SEEN,
	input wire logic [NUM_FRAMERS-1:0] RX_STORE_OVERFLOW,
	input wire logic [NUM_FRAMERS-1:0] RX_STORE_UNDERFLOW,
	input wire logic [NUM_FRAMERS-1:0] RX_FRAMING_BIT_STB,
	input wire logic [NUM_FRAMERS-1:0] RX_FRAMING_BIT_ERR,
	input wire logic [NUM_FRAMERS-1:0] RX_RESYNC_DONE,
	input wire logic [NUM_FRAMERS*ALIGN_W-1:0] RX_ALIGN_POS,
	input wire logic [NUM_FRAMERS-1:0] FIRST_STATUS_ACTIVE,
	input wire logic [NUM_FRAMERS-1:0] SECOND_STATUS_ACTIVE,
	output logic [2*NUM_FRAMERS-1:0] FRAMER_INTERRUPT_SUMMARY,
	output logic INT_N
);

	localparam int SUM_W = 2 * NUM_FRAMERS;
	localparam logic [2:0] SEVERE_LIMIT = 3'(FES_SEVERE_LIMIT);

	// ==========================================
	// Per-framer state, one element per framer
	logic [FES_REG_W-1:0] flags_r [NUM_FRAMERS];
	logic [FES_REG_W-1:0] flags_nxt [NUM_FRAMERS];
	logic [FES_REG_W-1:0] hold_r [NUM_FRAMERS];
	logic [FES_REG_W-1:0] hold_nxt [NUM_FRAMERS];
	logic [FES_SEVERE_WINDOW-1:0] hist_r [NUM_FRAMERS];
	logic [FES_SEVERE_WINDOW-1:0] hist_nxt [NUM_FRAMERS];
	logic [ALIGN_W-1:0] align_r [NUM_FRAMERS];
	logic [ALIGN_W-1:0] align_nxt [NUM_FRAMERS];
	logic align_valid_r [NUM_FRAMERS];
	logic align_valid_nxt [NUM_FRAMERS];
	logic [FES_REG_W-1:0] event_vec [NUM_FRAMERS];
	logic [NUM_FRAMERS-1:0] zero8_evt;
	logic [NUM_FRAMERS-1:0] zero16_evt;

	// ==========================================
	// Port and summary state
	logic [7:0] rd_data_r;
	logic [7:0] rd_data_nxt;
	logic rd_valid_r;
	logic rd_valid_nxt;
	logic [SUM_W-1:0] summary_r;
	logic [SUM_W-1:0] summary_nxt;
	logic int_n_r;
	logic int_n_nxt;
	logic [SUM_W-1:0] summary_live;

	genvar f;
	generate
		for (f = 0; f < NUM_FRAMERS; f++)
		begin : g_framer
			logic wr_hit;
			logic [2:0] err_count;
			logic [ALIGN_W-1:0] new_align;

			// Zero run watch on this framer's line
			fes_zero_run #(
				.SHORT_RUN(FES_ZERO_SHORT),
				.LONG_RUN(FES_ZERO_LONG)
			) u_zero_run (
				.clk(SYS_CLK),
				.rst(RESET),
				.bit_stb(RX_BIT_STB[f]),
				.line_pos(RX_LINE_POSITIVE[f]),
				.line_neg(RX_LINE_NEGATIVE[f]),
				.short_evt(zero8_evt[f]),
				.long_evt(zero16_evt[f])
			);

			// Event detection and the flag update for this framer
			always_comb
			begin
				wr_hit = WR_STB && (ADDR == FES_RX_EVENT_OFFSET) && (FRAMER_SEL == 2'(f));
				new_align = RX_ALIGN_POS[f*ALIGN_W +: ALIGN_W];
				hist_nxt[f] = hist_r[f];
				if (RX_FRAMING_BIT_STB[f])
					hist_nxt[f] = {hist_r[f][FES_SEVERE_WINDOW-2:0], RX_FRAMING_BIT_ERR[f]};
				err_count = '0;
				for (int i = 0; i < FES_SEVERE_WINDOW; i++)
					err_count = err_count + {2'b00, hist_nxt[f][i]};
				align_nxt[f] = align_r[f];
				align_valid_nxt[f] = align_valid_r[f];
				if (RX_RESYNC_DONE[f])
				begin
					align_nxt[f] = new_align;
					align_valid_nxt[f] = 1'b1;
				end
				event_vec[f] = '0;
				// First resync after reset has nothing to compare against
				event_vec[f][FES_BIT_ALIGN_CHANGE] = RX_RESYNC_DONE[f] && align_valid_r[f]
					&& (new_align != align_r[f]);
				event_vec[f][FES_BIT_EIGHT_ZERO] = zero8_evt[f];
				event_vec[f][FES_BIT_SIXTEEN_ZERO] = zero16_evt[f];
				event_vec[f][FES_BIT_STORE_FULL] = RX_STORE_OVERFLOW[f];
				event_vec[f][FES_BIT_STORE_EMPTY] = RX_STORE_UNDERFLOW[f];
				event_vec[f][FES_BIT_SEVERE_FRAMING] = RX_FRAMING_BIT_STB[f]
					&& (err_count >= SEVERE_LIMIT);
				event_vec[f][FES_BIT_B8ZS_SEEN] = RX_B8ZS_SEEN[f];
				event_vec[f][FES_BIT_FRAMING_ERROR] = RX_FRAMING_BIT_STB[f] && RX_FRAMING_BIT_ERR[f];
				// Masked write captures and clears only chosen bits; a new event wins over the clear
				hold_nxt[f] = hold_r[f];
				flags_nxt[f] = flags_r[f] | event_vec[f];
				if (wr_hit)
				begin
					hold_nxt[f] = (hold_r[f] & ~WR_DATA) | (flags_r[f] & WR_DATA);
					flags_nxt[f] = (flags_r[f] & ~WR_DATA) | event_vec[f];
				end
			end

			always_ff @(posedge SYS_CLK)
			begin
				if (RESET)
				begin
					flags_r[f] <= FES_REG_RESET;
					hold_r[f] <= FES_REG_RESET;
					hist_r[f] <= '0;
					align_r[f] <= '0;
					align_valid_r[f] <= 1'b0;
				end
				else
				begin
					flags_r[f] <= flags_nxt[f];
					hold_r[f] <= hold_nxt[f];
					hist_r[f] <= hist_nxt[f];
					align_r[f] <= align_nxt[f];
					align_valid_r[f] <= align_valid_nxt[f];
				end
			end

			// Two summary bits per framer, second above first
			assign summary_live[2*f+FES_SUM_FIRST] = FIRST_STATUS_ACTIVE[f];
			assign summary_live[2*f+FES_SUM_SECOND] = SECOND_STATUS_ACTIVE[f];
		end
	endgenerate

	// ==========================================
	// Read path, summary and shared interrupt
	always_comb
	begin
		summary_nxt = summary_live;
		// Any pending status event of any framer pulls the shared line low
		int_n_nxt = ~(|summary_live);
		rd_valid_nxt = RD_STB;
		rd_data_nxt = rd_data_r;
		if (RD_STB)
		begin
			if (ADDR == FES_RX_EVENT_OFFSET)
				rd_data_nxt = hold_r[FRAMER_SEL];
			else
				rd_data_nxt = 8'(summary_r);
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			rd_data_r <= FES_REG_RESET;
			rd_valid_r <= 1'b0;
			summary_r <= '0;
			int_n_r <= 1'b1;
		end
		else
		begin
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
			summary_r <= summary_nxt;
			int_n_r <= int_n_nxt;
		end
	end

	assign RD_DATA = rd_data_r;
	assign RD_VALID = rd_valid_r;
	assign FRAMER_INTERRUPT_SUMMARY = summary_r;
	assign INT_N = int_n_r;

endmodule

/* File: tb/fes_status_assertions.sv */
// Checker for the register port and interrupt outputs
`timescale 1ns/1ns
module fes_status_assertions
	import fes_pkg::*;
#(
	parameter int NUM_FRAMERS = FES_NUM_FRAMERS
)
(
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic [7:0] ADDR,
	input wire logic RD_STB,
	input wire logic [7:0] RD_DATA,
	input wire logic RD_VALID,
	input wire logic [NUM_FRAMERS-1:0] FIRST_STATUS_ACTIVE,
	input wire logic [NUM_FRAMERS-1:0] SECOND_STATUS_ACTIVE,
	input wire logic [2*NUM_FRAMERS-1:0] FRAMER_INTERRUPT_SUMMARY,
	input wire logic INT_N
);
	// ==========================================
	// Expected summary, second bit above first
	logic [2*NUM_FRAMERS-1:0] sum_exp;
	always_comb
		for (int f = 0; f < NUM_FRAMERS; f++)
			sum_exp[2*f +: 2] = {SECOND_STATUS_ACTIVE[f], FIRST_STATUS_ACTIVE[f]};

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);

	// ==========================================
	// Properties; reset guards keep stale samples out
	chk_read_answer: assert property (RD_STB |=> RD_VALID) else $error("read unanswered");
	chk_valid_pulse: assert property (!RD_STB |=> !RD_VALID) else $error("stray valid");
	chk_summary_map: assert property (!$past(RESET) |-> FRAMER_INTERRUPT_SUMMARY == $past(sum_exp))
		else $error("summary bit order wrong");
	chk_int_summary: assert property (INT_N == (FRAMER_INTERRUPT_SUMMARY == '0)) else $error("int vs summary");
	chk_int_raise: assert property ((|sum_exp) |=> !INT_N) else $error("interrupt not raised");
	chk_int_drop: assert property ((sum_exp == '0) ##1 1'b1 |-> INT_N) else $error("interrupt stuck");
	chk_unused_read: assert property (RD_STB && ADDR != FES_RX_EVENT_OFFSET |=>
		RD_DATA == $past(FRAMER_INTERRUPT_SUMMARY)) else $error("unused address not summary");
	chk_data_hold: assert property (!RD_VALID && !$past(RESET) |-> $stable(RD_DATA)) else $error("data moved");
	cover property (RD_STB && ADDR == FES_RX_EVENT_OFFSET);
	cover property (!INT_N);
	cover property (RD_VALID && RD_DATA != '0);
endmodule

/* File: tb/fes_host_model.sv */
// Host processor model on the parallel control port
`timescale 1ns/1ns
module fes_host_model
(
	input wire logic clk,
	output logic [1:0] sel,
	output logic [7:0] addr,
	output logic wr_stb,
	output logic rd_stb,
	output logic [7:0] wr_data,
	input wire logic [7:0] rd_data
);
	initial {sel, addr, wr_stb, rd_stb, wr_data} = '0;
	// One strobe pulse; released addr and wr_data show inverted values, while sel keeps its value
	task automatic access(logic w, logic [1:0] f, logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		sel = f;
		addr = a;
		wr_data = d;
		wr_stb = w;
		rd_stb = !w;
		@(negedge clk);
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		addr = ~addr;
		wr_data = ~wr_data;
	endtask
	// Write mask, read, write back what the port really returned under the mask
	task automatic poll(logic [1:0] f, logic [7:0] a, logic [7:0] m);
		logic [7:0] seen;
		access(1'b1, f, a, m);
		access(1'b0, f, a, 8'h00);
		// Read data stands from the edge after the strobe until the next read
		seen = rd_data;
		access(1'b1, f, a, seen & m);
	endtask
endmodule

/* File: tb/tb_fes_status_top.sv */
// Self-checking bench for the framer event status block
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_fes_status_top
	import fes_pkg::*;
;
	logic SYS_CLK = 1'b0;
	logic RESET = 1'b1;
	logic [3:0] sig [6];
	logic [3:0] lp = '0;
	logic [3:0] ln = '0;
	logic [3:0] fe = '0;
	logic [3:0] act1 = '0;
	logic [3:0] act2 = '0;
	logic [31:0] al = '0;
	logic [1:0] sel;
	logic [7:0] addr, wdat, RD_DATA, SUM, want;
	logic wstb, rstb, RD_VALID, INT_N;
	logic [7:0] exp_q [$];
	int fails = 0;
	int comparisons = 0;
	int zlen [5] = '{7, 8, 15, 16, 40};
	logic [7:0] zexp [5] = '{8'h00, 8'h40, 8'h40, 8'h60, 8'h60};
	logic [7:0] bitv [4] = '{8'h00, 8'h02, 8'h10, 8'h08};
	logic [8:0] fseq = 9'h141;
	logic [7:0] apos [3] = '{8'h05, 8'h05, 8'h09};
	always #20 SYS_CLK = ~SYS_CLK;

	fes_status_top fes_status_top_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .FRAMER_SEL(sel), .ADDR(addr),
		.WR_STB(wstb), .RD_STB(rstb), .WR_DATA(wdat), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
		.RX_BIT_STB(sig[0]), .RX_LINE_POSITIVE(lp), .RX_LINE_NEGATIVE(ln), .RX_B8ZS_SEEN(sig[1]),
		.RX_STORE_OVERFLOW(sig[2]), .RX_STORE_UNDERFLOW(sig[3]), .RX_FRAMING_BIT_STB(sig[4]),
		.RX_FRAMING_BIT_ERR(fe), .RX_RESYNC_DONE(sig[5]), .RX_ALIGN_POS(al), .FIRST_STATUS_ACTIVE(act1),
		.SECOND_STATUS_ACTIVE(act2), .FRAMER_INTERRUPT_SUMMARY(SUM), .INT_N(INT_N));
	fes_host_model fes_host_model_inst (.clk(SYS_CLK), .sel(sel), .addr(addr), .wr_stb(wstb), .rd_stb(rstb),
		.wr_data(wdat), .rd_data(RD_DATA));

	// Read results are matched in order against the driver's notes
	always @(negedge SYS_CLK)
		if (RD_VALID === 1'b1)
		begin
			want = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
			`CHK(RD_DATA, want)
		end

	task automatic pulse(int k, int f);
		@(negedge SYS_CLK);
		sig[k][f] = 1'b1;
		@(negedge SYS_CLK);
		sig[k][f] = 1'b0;
	endtask

	task automatic poll(logic [1:0] f, logic [7:0] m, logic [7:0] e);
		exp_q.push_back(e);
		fes_host_model_inst.poll(f, FES_RX_EVENT_OFFSET, m);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge SYS_CLK);
		fails++;
		$display("BAD %0t run timed out", $time);
		end_of_test;
	end

	// ==========================================
	// Main sequence
	initial
	begin
		for (int i = 0; i < 6; i++)
			sig[i] = '0;
		void'($urandom(88));
		repeat (10) @(negedge SYS_CLK);
		RESET = 1'b0;
		// Random pending levels, read back at unused addresses
		for (int i = 0; i < 5; i++)
		begin
			{act2, act1} = (i == 4) ? 8'h00 : 8'($urandom);
			repeat (2) @(negedge SYS_CLK);
			`CHK(INT_N, ~|{act2, act1})
			exp_q.push_back({act2[3], act1[3], act2[2], act1[2], act2[1], act1[1], act2[0], act1[0]});
			fes_host_model_inst.access(1'b0, 2'($urandom), 8'($urandom % 34), 8'h00);
		end
		// Codeword and store events, then clear
		for (int k = 1; k < 4; k++)
		begin
			pulse(k, k);
			poll(2'(k), 8'hFF, bitv[k]);
			poll(2'(k), 8'hFF, 8'h00);
		end
		// Partial masks leave the other latched flag untouched
		pulse(2, 0);
		pulse(3, 0);
		poll(2'd0, 8'h10, 8'h10);
		poll(2'd0, 8'h08, 8'h08);
		poll(2'd0, 8'hFF, 8'h00);
		// Zero runs around both thresholds and a long run
		foreach (zlen[i])
		begin
			{lp, ln} = 8'h00;
			repeat (zlen[i]) pulse(0, 1);
			// A mark on either rail ends the run
			{lp, ln} = (i % 2 == 0) ? 8'hF0 : 8'h0F;
			pulse(0, 1);
			poll(2'd1, 8'hFF, zexp[i]);
		end
		// Errors six apart stay mild, two within six are severe
		for (int i = 0; i < 9; i++)
		begin
			fe[2] = fseq[i];
			pulse(4, 2);
			if (i == 6)
				poll(2'd2, 8'hFF, 8'h01);
		end
		poll(2'd2, 8'hFF, 8'h05);
		// First resync and a repeat give no alignment change
		foreach (apos[i])
		begin
			al[31:24] = apos[i];
			pulse(5, 3);
			poll(2'd3, 8'hFF, (i == 2) ? 8'h80 : 8'h00);
		end
		repeat (4) @(negedge SYS_CLK);
		if (exp_q.size() != 0)
		begin
			fails++;
			$display("BAD %0t reads never answered", $time);
		end
		end_of_test;
	end
endmodule

bind fes_status_top fes_status_assertions #(.NUM_FRAMERS(NUM_FRAMERS)) fes_status_assertions_inst (
	.SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
	.FIRST_STATUS_ACTIVE(FIRST_STATUS_ACTIVE), .SECOND_STATUS_ACTIVE(SECOND_STATUS_ACTIVE),
	.FRAMER_INTERRUPT_SUMMARY(FRAMER_INTERRUPT_SUMMARY), .INT_N(INT_N));
